/* File: odcr_pkg.sv */
`default_nettype none

// Shared constants and carriers of the second output's fast-rate driver controls.
package odcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_EMPHASIS  = 8'h2c; // Fast-rate emphasis configuration.
  localparam logic [7:0]  IDX_SWING     = 8'h2d; // Fast-rate swing configuration.
  localparam logic [7:0]  IDX_SLEW_CTRL = 8'h30; // Slew selection control and status.
  localparam logic [1:0]  WORD_LSB      = 2'h0;  // Low address bits of an aligned word.

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values of the two stored configuration words, reserved bits included, and of the slew control.
  localparam logic [15:0] RST_EMPHASIS  = 16'h0805; // Pulse length 8, on, level 5.
  localparam logic [15:0] RST_SWING     = 16'h1980; // Swing 0x19, reserved low byte 0x80.
  localparam logic [2:0]  RST_SLEW_CTRL = 3'h0;     // Manual mode, bypass slew.

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions inside the configuration words.
  localparam int PULSE_LSB = 8;  // Emphasis pulse length, bits 12:8.
  localparam int PULSE_MSB = 12;
  localparam int OFF_BIT   = 6;  // Emphasis driver power down, bit 6.
  localparam int LEVEL_LSB = 0;  // Emphasis level, bits 5:0.
  localparam int LEVEL_MSB = 5;
  localparam int SWING_LSB = 8;  // Swing level, bits 13:8.
  localparam int SWING_MSB = 13;

  // Field positions inside the slew control word.
  localparam int AUTO_BIT       = 0;  // Automatic slew selection enable.
  localparam int MAN_SLEW_LSB   = 1;  // Manual slew code, bits 2:1.
  localparam int MAN_SLEW_MSB   = 2;
  localparam int LOCK_BIT       = 4;  // Recovery loop lock, read only.
  localparam int RATE_LSB       = 5;  // Locked rate, read only, bits 6:5.
  localparam int RATE_MSB       = 6;
  localparam int EFF_SLEW_LSB   = 8;  // Slew now applied, read only, bits 9:8.
  localparam int EFF_SLEW_MSB   = 9;

  ////////////////////////////////////////////////////////////////////////////////
  // Rates at which the recovery loop can lock.
  typedef enum logic [1:0] {
    RATE_MADI,
    RATE_SD,
    RATE_HD,
    RATE_3G
  } odcr_rate_t;

  // Slew settings of the output driver.
  typedef enum logic [1:0] {
    SLEW_BYPASS,
    SLEW_SLOW,
    SLEW_FAST
  } odcr_slew_t;

  // Controls carried to the analog driver of the second serial output.
  typedef struct packed {
    logic [4:0] second_out_fast_emphasis_pulse_len; // Emphasis pulse width code.
    logic       second_out_fast_emphasis_off;       // High powers emphasis down.
    logic [5:0] second_out_fast_emphasis_level;     // Emphasis amplitude code.
    logic [5:0] second_out_fast_swing_level;        // Swing code, ~26 mVpp steps.
    odcr_slew_t slew;                               // Slew applied to the output.
  } odcr_drive_t;

endpackage : odcr_pkg

`default_nettype wire

/* File: odcr_regs.sv */
`default_nettype none

module odcr_regs #(
  parameter int ADDR_W = 12 // Width of the APB byte address.
) (
  input  wire logic                 pclk,      // Bus clock, 200 MHz.
  input  wire logic                 presetn,   // Asynchronous reset, active low.
  input  wire logic                 pclk_en,   // Clock enable; low freezes all state.
  input  wire logic                 psel,      // APB select.
  input  wire logic                 penable,   // APB access phase.
  input  wire logic                 pwrite,    // APB direction, high for write.
  input  wire logic [ADDR_W-1:0]    paddr,     // APB byte address.
  input  wire logic [31:0]          pwdata,    // APB write data.
  input  wire logic [3:0]           pstrb,     // APB write byte strobes.
  output var  logic [31:0]          prdata,    // APB read data.
  output var  logic                 pready,    // APB ready, one access cycle.
  output var  logic                 pslverr,   // APB error for unmapped address.
  input  wire logic                 cdr_locked, // Recovery loop is locked.
  input  wire odcr_pkg::odcr_rate_t cdr_rate,  // Rate of the locked loop.
  output var  odcr_pkg::odcr_drive_t drive     // Controls of the output driver.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Merge the two low byte lanes of a write into a stored word.
  function automatic logic [15:0] merge_lanes(input logic [15:0] old_word,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb);
    logic [15:0] word;
    word = old_word;
    if (strb[0]) begin
      word[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      word[15:8] = wdata[15:8];
    end
    return word;
  endfunction : merge_lanes

  // Map the locked rate onto a slew: slow for the low rates, fast for HD and 3G.
  function automatic odcr_pkg::odcr_slew_t rate_to_slew(input odcr_pkg::odcr_rate_t rate);
    odcr_pkg::odcr_slew_t s;
    s = odcr_pkg::SLEW_SLOW;
    case (rate)
      odcr_pkg::RATE_HD: s = odcr_pkg::SLEW_FAST;
      odcr_pkg::RATE_3G: s = odcr_pkg::SLEW_FAST;
      default:           s = odcr_pkg::SLEW_SLOW;
    endcase
    return s;
  endfunction : rate_to_slew

  // Decode a manual slew code; the unused code falls back to bypass.
  function automatic odcr_pkg::odcr_slew_t code_to_slew(input logic [1:0] code);
    odcr_pkg::odcr_slew_t s;
    s = odcr_pkg::SLEW_BYPASS;
    case (code)
      2'h1:    s = odcr_pkg::SLEW_SLOW;
      2'h2:    s = odcr_pkg::SLEW_FAST;
      default: s = odcr_pkg::SLEW_BYPASS;
    endcase
    return s;
  endfunction : code_to_slew

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [15:0] emphasis_word; // Whole emphasis word, reserved bits kept as written.
  logic [15:0] swing_word;    // Whole swing word, reserved bits kept as written.
  logic [2:0]  slew_ctrl;     // Automatic enable and manual slew code.

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode and bus phases.

  localparam logic [ADDR_W-1:0] ADDR_EMPHASIS =
    ADDR_W'({odcr_pkg::IDX_EMPHASIS, odcr_pkg::WORD_LSB});  // Emphasis byte address.
  localparam logic [ADDR_W-1:0] ADDR_SWING =
    ADDR_W'({odcr_pkg::IDX_SWING, odcr_pkg::WORD_LSB});     // Swing byte address.
  localparam logic [ADDR_W-1:0] ADDR_SLEW_CTRL =
    ADDR_W'({odcr_pkg::IDX_SLEW_CTRL, odcr_pkg::WORD_LSB}); // Slew control address.

  wire logic hit_emphasis = (paddr == ADDR_EMPHASIS);  // Emphasis word addressed.
  wire logic hit_swing    = (paddr == ADDR_SWING);     // Swing word addressed.
  wire logic hit_ctrl     = (paddr == ADDR_SLEW_CTRL); // Slew control addressed.
  wire logic hit_any      = hit_emphasis | hit_swing | hit_ctrl; // Mapped address.

  // Setup phase: the answer is prepared so that the first access cycle completes.
  wire logic setup_phase  = psel & ~penable;
  // Completing access: the only edge at which a write takes effect.
  wire logic access_done  = psel & penable & pready;
  wire logic write_commit = access_done & pwrite & hit_any;

  ////////////////////////////////////////////////////////////////////////////////
  // Next values of the stored words.

  wire logic [15:0] next_emphasis = (write_commit & hit_emphasis) ?
                                    merge_lanes(emphasis_word, pwdata, pstrb) :
                                    emphasis_word;
  wire logic [15:0] next_swing    = (write_commit & hit_swing) ?
                                    merge_lanes(swing_word, pwdata, pstrb) :
                                    swing_word;
  wire logic        ctrl_lane0    = write_commit & hit_ctrl & pstrb[0];
  wire logic [2:0]  next_slew_ctrl = ctrl_lane0 ?
                                     pwdata[odcr_pkg::MAN_SLEW_MSB:odcr_pkg::AUTO_BIT] :
                                     slew_ctrl;

  // Slew selection: in automatic mode the locked rate decides, unlocked means bypass.
  wire odcr_pkg::odcr_slew_t auto_slew   = cdr_locked ? rate_to_slew(cdr_rate) :
                                           odcr_pkg::SLEW_BYPASS;
  wire odcr_pkg::odcr_slew_t manual_slew =
    code_to_slew(next_slew_ctrl[odcr_pkg::MAN_SLEW_MSB:odcr_pkg::MAN_SLEW_LSB]);
  wire odcr_pkg::odcr_slew_t next_slew   = next_slew_ctrl[odcr_pkg::AUTO_BIT] ?
                                           auto_slew : manual_slew;

  // Status view of the slew control word.
  wire logic [31:0] ctrl_view = {22'h0, drive.slew, 1'b0, cdr_rate, cdr_locked,
                                 1'b0, slew_ctrl};

  // Read multiplexer; bits above the 16-bit words read as zero.
  wire logic [31:0] next_rdata = hit_emphasis ? {16'h0, emphasis_word} :
                                 hit_swing    ? {16'h0, swing_word} :
                                 hit_ctrl     ? ctrl_view : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration storage; reserved bits of the emphasis and swing words are stored so software can restore them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emphasis_word <= odcr_pkg::RST_EMPHASIS;
      swing_word    <= odcr_pkg::RST_SWING;
      slew_ctrl     <= odcr_pkg::RST_SLEW_CTRL;
    end else if (pclk_en) begin
      emphasis_word <= next_emphasis;
      swing_word    <= next_swing;
      slew_ctrl     <= next_slew_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer: ready for exactly the first access cycle, data latched at setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (pclk_en) begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0 : next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Driver controls come from flops loaded with the post-write value, so a new
  // field reaches the driver on the same edge that completes the write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '{
        second_out_fast_emphasis_pulse_len:
          odcr_pkg::RST_EMPHASIS[odcr_pkg::PULSE_MSB:odcr_pkg::PULSE_LSB],
        second_out_fast_emphasis_off: odcr_pkg::RST_EMPHASIS[odcr_pkg::OFF_BIT],
        second_out_fast_emphasis_level:
          odcr_pkg::RST_EMPHASIS[odcr_pkg::LEVEL_MSB:odcr_pkg::LEVEL_LSB],
        second_out_fast_swing_level:
          odcr_pkg::RST_SWING[odcr_pkg::SWING_MSB:odcr_pkg::SWING_LSB],
        slew: odcr_pkg::SLEW_BYPASS
      };
    end else if (pclk_en) begin
      drive.second_out_fast_emphasis_pulse_len <=
        next_emphasis[odcr_pkg::PULSE_MSB:odcr_pkg::PULSE_LSB];
      drive.second_out_fast_emphasis_off <= next_emphasis[odcr_pkg::OFF_BIT];
      drive.second_out_fast_emphasis_level <=
        next_emphasis[odcr_pkg::LEVEL_MSB:odcr_pkg::LEVEL_LSB];
      drive.second_out_fast_swing_level <=
        next_swing[odcr_pkg::SWING_MSB:odcr_pkg::SWING_LSB];
      drive.slew <= next_slew;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A completing write with the upper lane enabled.
  sequence s_write_hi(logic hit);
    pclk_en && access_done && pwrite && hit && pstrb[1];
  endsequence

  // A completing write with the lower lane enabled.
  sequence s_write_lo(logic hit);
    pclk_en && access_done && pwrite && hit && pstrb[0];
  endsequence

  // A setup cycle followed by the completing access of a read.
  sequence s_read(logic hit);
    pclk_en && setup_phase && !pwrite && hit ##1 pclk_en && access_done;
  endsequence

  chk_pulse_write: assert property (s_write_hi(hit_emphasis) |=>
    drive.second_out_fast_emphasis_pulse_len ==
    $past(pwdata[odcr_pkg::PULSE_MSB:odcr_pkg::PULSE_LSB]))
    else $error("pulse length did not follow the write");

  chk_off_write: assert property (s_write_lo(hit_emphasis) |=>
    drive.second_out_fast_emphasis_off == $past(pwdata[odcr_pkg::OFF_BIT]))
    else $error("emphasis power down did not follow the write");

  chk_level_write: assert property (s_write_lo(hit_emphasis) |=>
    drive.second_out_fast_emphasis_level ==
    $past(pwdata[odcr_pkg::LEVEL_MSB:odcr_pkg::LEVEL_LSB]))
    else $error("emphasis level did not follow the write");

  chk_swing_write: assert property (s_write_hi(hit_swing) |=>
    drive.second_out_fast_swing_level ==
    $past(pwdata[odcr_pkg::SWING_MSB:odcr_pkg::SWING_LSB]))
    else $error("swing level did not follow the write");

  chk_auto_locked: assert property (
    pclk_en && next_slew_ctrl[odcr_pkg::AUTO_BIT] && cdr_locked |=>
    drive.slew == rate_to_slew($past(cdr_rate)))
    else $error("automatic slew does not match the locked rate");

  chk_auto_unlock: assert property (
    pclk_en && next_slew_ctrl[odcr_pkg::AUTO_BIT] && !cdr_locked |=>
    drive.slew == odcr_pkg::SLEW_BYPASS)
    else $error("unlocked automatic slew is not bypass");

  chk_read_back: assert property (s_read(hit_emphasis) |->
    prdata == {16'h0, emphasis_word})
    else $error("emphasis read does not return the stored word");

  chk_ready_pulse: assert property (
    pclk_en && setup_phase |=> pready ##1 (!$past(pclk_en) || !pready))
    else $error("ready is not a single access cycle");

  chk_hold_fields: assert property (
    pclk_en && !write_commit |=> $stable(emphasis_word) && $stable(swing_word))
    else $error("configuration changed without a write");

  chk_unmapped_err: assert property (
    pclk_en && setup_phase && !hit_any |=> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule : odcr_regs

`default_nettype wire

/* File: out1_hd_driver_config_regs_bench.sv */
`default_nettype none

// Self-checking bench for the fast-rate driver controls of the second serial output.
module out1_hd_driver_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte addresses are four times the register index.
  localparam logic [11:0] A_EMPH  = {2'h0, odcr_pkg::IDX_EMPHASIS, odcr_pkg::WORD_LSB};
  localparam logic [11:0] A_SWING = {2'h0, odcr_pkg::IDX_SWING, odcr_pkg::WORD_LSB};
  localparam logic [11:0] A_SLEW  = {2'h0, odcr_pkg::IDX_SLEW_CTRL, odcr_pkg::WORD_LSB};
  localparam logic [11:0] A_NONE  = 12'h100; // Nothing is mapped here.

  logic                  pclk;       // Bus clock.
  logic                  presetn;    // Reset, active low.
  logic                  pclk_en;    // Clock enable.
  logic                  psel;       // APB select.
  logic                  penable;    // APB access phase.
  logic                  pwrite;     // APB direction.
  logic [11:0]           paddr;      // APB byte address.
  logic [31:0]           pwdata;     // APB write data.
  logic [3:0]            pstrb;      // APB byte strobes.
  logic [31:0]           prdata;     // APB read data.
  logic                  pready;     // APB ready.
  logic                  pslverr;    // APB error.
  logic                  cdr_locked; // Recovery loop lock.
  odcr_pkg::odcr_rate_t  cdr_rate;   // Locked rate.
  odcr_pkg::odcr_drive_t drive;      // Driver controls.
  int                    errors;     // Mismatches seen.
  int                    cmp_count;  // Comparisons made.

  odcr_regs #(.ADDR_W(12)) uut (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cdr_locked(cdr_locked), .cdr_rate(cdr_rate),
    .drive(drive)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Compare one value and report a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Print the verdict and stop; reached from the main sequence or the watchdog.
  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     input logic [3:0] sb, output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    pstrb   <= sb;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Full-word write to a mapped register; it must not be refused.
  task automatic wr_reg(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, addr, wd, 4'hf, rd, err);
    check({31'h0, err}, 32'h0);
    #1;
  endtask : wr_reg

  // Read a register and compare the word with what is expected.
  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr, 32'h0, 4'h0, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, exp_err});
  endtask : rd_chk

  // Compare the four configuration fields carried to the driver.
  task automatic chk_drive(input logic [4:0] pl, input logic off, input logic [5:0] lv,
                           input logic [5:0] sw);
    check({27'h0, drive.second_out_fast_emphasis_pulse_len}, {27'h0, pl});
    check({31'h0, drive.second_out_fast_emphasis_off}, {31'h0, off});
    check({26'h0, drive.second_out_fast_emphasis_level}, {26'h0, lv});
    check({26'h0, drive.second_out_fast_swing_level}, {26'h0, sw});
  endtask : chk_drive

  ////////////////////////////////////////////////////////////////////////////////
  // Reset contents, both on the driver controls and as read back.
  task automatic t_reset;
    chk_drive(5'h8, 1'b0, 6'h5, 6'h19);
    rd_chk(A_EMPH, 32'h0000_0805, 1'b0);
    rd_chk(A_SWING, 32'h0000_1980, 1'b0);
  endtask : t_reset

  // Field boundaries, written back to back; reserved bits keep their reset contents.
  task automatic t_fields;
    wr_reg(A_EMPH, 32'h0000_0f4f);
    chk_drive(5'hf, 1'b1, 6'hf, 6'h19);
    wr_reg(A_SWING, 32'h0000_1f80);
    chk_drive(5'hf, 1'b1, 6'hf, 6'h1f);
    wr_reg(A_EMPH, 32'h0000_0000);
    chk_drive(5'h0, 1'b0, 6'h0, 6'h1f);
    rd_chk(A_EMPH, 32'h0000_0000, 1'b0);
    rd_chk(A_SWING, 32'h0000_1f80, 1'b0);
  endtask : t_fields

  // Unmapped address: refused, and the swing word is not disturbed.
  task automatic t_unmapped;
    logic [31:0] rd;
    logic        err;
    apb(1'b1, A_NONE, 32'h0000_ffff, 4'hf, rd, err);
    check({31'h0, err}, 32'h1);
    rd_chk(A_NONE, 32'h0, 1'b1);
    rd_chk(A_SWING, 32'h0000_1f80, 1'b0);
  endtask : t_unmapped

  // Apply recovery state and look at the slew two edges later.
  task automatic slew_at(input logic lk, input int r, input odcr_pkg::odcr_slew_t exp);
    @(posedge pclk);
    cdr_locked <= lk;
    cdr_rate   <= odcr_pkg::odcr_rate_t'(r);
    @(posedge pclk);
    @(posedge pclk);
    #1;
    check({30'h0, drive.slew}, {30'h0, exp});
  endtask : slew_at

  // Automatic slew per locked rate, fallback when unlocked, then a frozen clock enable.
  task automatic t_slew;
    wr_reg(A_SLEW, 32'h0000_0001);
    for (int r = 0; r < 4; r++) begin
      slew_at(1'b1, r, (r < 2) ? odcr_pkg::SLEW_SLOW : odcr_pkg::SLEW_FAST);
    end
    slew_at(1'b0, 3, odcr_pkg::SLEW_BYPASS);
    slew_at(1'b1, 0, odcr_pkg::SLEW_SLOW);
    @(posedge pclk);
    pclk_en    <= 1'b0;
    cdr_locked <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    check({30'h0, drive.slew}, {30'h0, odcr_pkg::SLEW_SLOW});
    @(posedge pclk);
    pclk_en <= 1'b1;
    slew_at(1'b0, 0, odcr_pkg::SLEW_BYPASS);
  endtask : t_slew

  // Manual slew codes, single-lane writes and the status view, then a reset in mid-run.
  // The lane writes prove that a disabled lane keeps its stored byte.
  task automatic t_manual;
    logic [31:0] rd;
    logic        err;
    @(posedge pclk);
    cdr_locked <= 1'b1;
    cdr_rate   <= odcr_pkg::RATE_HD;
    wr_reg(A_SLEW, 32'h0000_0002);
    check({30'h0, drive.slew}, {30'h0, odcr_pkg::SLEW_SLOW});
    rd_chk(A_SLEW, 32'h0000_0152, 1'b0);
    wr_reg(A_SLEW, 32'h0000_0004);
    check({30'h0, drive.slew}, {30'h0, odcr_pkg::SLEW_FAST});
    wr_reg(A_SLEW, 32'h0000_0006);
    check({30'h0, drive.slew}, {30'h0, odcr_pkg::SLEW_BYPASS});
    apb(1'b1, A_EMPH, 32'h0000_0aff, 4'h2, rd, err);
    #1;
    chk_drive(5'ha, 1'b0, 6'h0, 6'h1f);
    apb(1'b1, A_EMPH, 32'h0000_1f45, 4'h1, rd, err);
    #1;
    chk_drive(5'ha, 1'b1, 6'h5, 6'h1f);
    rd_chk(A_EMPH, 32'h0000_0a45, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk_drive(5'h8, 1'b0, 6'h5, 6'h19);
    check({30'h0, drive.slew}, {30'h0, odcr_pkg::SLEW_BYPASS});
    rd_chk(A_SLEW, 32'h0000_0050, 1'b0);
  endtask : t_manual

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end

  // Main sequence; reset is held for 12 cycles.
  initial begin
    errors     = 0;
    cmp_count  = 0;
    presetn    = 1'b0;
    pclk_en    = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h0;
    pwdata     = 32'h0;
    pstrb      = 4'h0;
    cdr_locked = 1'b0;
    cdr_rate   = odcr_pkg::RATE_MADI;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    t_fields();
    t_unmapped();
    t_slew();
    t_manual();
    tally_and_finish();
  end

endmodule : out1_hd_driver_config_regs_bench

`default_nettype wire
